// *** design/scl_entry_decode.sv ***
`default_nettype none

module scl_entry_decode #(
    parameter bit FIXED_DITHER = 1'b0
) (
    input  wire logic              [31:0] entry_i,
    output scl_pkg::scl_node_t            pos_node_o,
    output logic                   [5:0]  pos_chan_o,
    output scl_pkg::scl_node_t            neg_node_o,
    output logic                   [5:0]  neg_chan_o,
    output logic                   [2:0]  gain_code_o,
    output logic                   [7:0]  gain_sel_o,
    output logic                          unipolar_o,
    output logic                          dither_o,
    output logic                          ghost_o,
    output logic                          trig_o,
    output logic                          end_o
);
    import scl_pkg::*;

    wire [15:0] lo   = entry_i[15:0];
    wire [15:0] hi   = entry_i[31:16];
    wire [2:0]  kind = hi[SCL_KIND_LSB +: SCL_KIND_W];
    wire [1:0]  bank = hi[SCL_BANK_LSB +: SCL_BANK_W];
    wire [3:0]  chan = hi[SCL_CHAN_LSB +: SCL_CHAN_W];
    wire        low8 = ~chan[3];

    // fixed dither variants ignore the bit
    assign dither_o    = FIXED_DITHER | lo[SCL_DITHER_BIT];
    assign unipolar_o  = lo[SCL_POL_BIT];
    assign gain_code_o = lo[SCL_GAIN_LSB +: SCL_GAIN_W];
    assign trig_o      = lo[SCL_TRIG_BIT];
    assign end_o       = lo[SCL_END_BIT];
    assign ghost_o     = (kind == SCL_KIND_GHOST);

    // one select line per gain code 0.5..100
    for (genvar g = 0; g < SCL_GAIN_N; g++) begin : g_gain
        assign gain_sel_o[g] = (gain_code_o == 3'(g));
    end

    always_comb begin
        pos_node_o = SCL_NODE_OPEN;
        neg_node_o = SCL_NODE_OPEN;
        // bank picks the group of sixteen
        pos_chan_o = {bank, chan};
        neg_chan_o = {bank, chan};
        case (kind)
            // fixed calibration pairs, upper codes open
            SCL_KIND_CAL: begin
                case (chan)
                    4'h0: begin
                        pos_node_o = SCL_NODE_AO_GND;
                        neg_node_o = SCL_NODE_AO_GND;
                    end
                    4'h1: begin
                        pos_node_o = SCL_NODE_AO_GND;
                        neg_node_o = SCL_NODE_AI_GND;
                    end
                    4'h2: begin
                        pos_node_o = SCL_NODE_DAC0;
                        neg_node_o = SCL_NODE_AO_GND;
                    end
                    4'h3: begin
                        pos_node_o = SCL_NODE_DAC1;
                        neg_node_o = SCL_NODE_AO_GND;
                    end
                    4'h4: begin
                        pos_node_o = SCL_NODE_REF;
                        neg_node_o = SCL_NODE_REF;
                    end
                    4'h5: begin
                        pos_node_o = SCL_NODE_REF;
                        neg_node_o = SCL_NODE_AI_GND;
                    end
                    4'h6: begin
                        pos_node_o = SCL_NODE_DAC0;
                        neg_node_o = SCL_NODE_REF;
                    end
                    4'h7: begin
                        pos_node_o = SCL_NODE_DAC1;
                        neg_node_o = SCL_NODE_REF;
                    end
                    default: begin
                        pos_node_o = SCL_NODE_OPEN;
                        neg_node_o = SCL_NODE_OPEN;
                    end
                endcase
            end
            SCL_KIND_PAIRED: begin
                if (low8) begin
                    pos_node_o = SCL_NODE_INPUT;
                    neg_node_o = SCL_NODE_INPUT;
                    neg_chan_o = {bank, chan + SCL_PAIR_OFS};
                end
            end
            SCL_KIND_FLOATING: begin
                pos_node_o = SCL_NODE_INPUT;
                neg_node_o = SCL_NODE_SENSE;
            end
            // input n against analog input ground
            SCL_KIND_GROUNDED: begin
                pos_node_o = SCL_NODE_INPUT;
                neg_node_o = SCL_NODE_AI_GND;
            end
            default: begin
                pos_node_o = SCL_NODE_OPEN;
                neg_node_o = SCL_NODE_OPEN;
            end
        endcase
    end

endmodule // scl_entry_decode

`default_nettype wire

// *** design/scl_entry_mem.sv ***
`default_nettype none

module scl_entry_mem #(
    parameter int DEPTH = 512,
    parameter int AW    = 9
) (
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        low_wr_i,
    input  wire logic        high_wr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        clear_i,
    input  wire logic        step_i,
    output logic      [31:0] entry_o,
    output logic      [AW-1:0] rd_ptr_o,
    output logic      [AW:0]   count_o,
    output logic             full_o
);
    import scl_pkg::*;

    logic [31:0]   mem [DEPTH];
    logic [15:0]   low_q;
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0]   count_q;

    wire           full     = (count_q == (AW+1)'(DEPTH));
    wire           do_write = high_wr_i & ~full & ~clear_i;
    wire           last_rd  = ((AW+1)'(rd_ptr_q) + (AW+1)'(1)) >= count_q;

    // low half waits for its high half
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            low_q <= SCL_LOW_RST;
        end else if (low_wr_i) begin
            low_q <= wdata_i;
        end
    end

    // entries stored in order of writing
    // the controller's clear or reset empties the list
    always_ff @(posedge mclk_i) begin
        if (clear_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i][31:16] <= 16'h0000;
            end
        end else if (do_write) begin
            mem[wr_ptr_q] <= {wdata_i, low_q};
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else if (clear_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            // pointer advances after the high half
            if (do_write) begin
                wr_ptr_q <= wr_ptr_q + AW'(1);
                count_q  <= count_q + (AW+1)'(1);
            end
            // stepping wraps back to the first entry
            if (step_i && count_q != '0) begin
                rd_ptr_q <= last_rd ? '0 : rd_ptr_q + AW'(1);
            end
        end
    end

    assign entry_o  = mem[rd_ptr_q];
    assign rd_ptr_o = rd_ptr_q;
    assign count_o  = count_q;
    assign full_o   = full;

endmodule // scl_entry_mem

`default_nettype wire

// *** design/scl_entry_top.sv ***
`default_nettype none

module scl_entry_top
    import scl_pkg::*;
#(
    parameter int DEPTH        = 512,
    parameter int AW           = 9,
    parameter int ADC_W        = 12,
    parameter bit FIXED_DITHER = 1'b0
) (
    input  wire logic                     mclk_i,
    input  wire logic                     rstn_i,
    input  wire logic                     wr_en_i,
    input  wire logic               [4:0] addr_i,
    input  wire logic              [15:0] wdata_i,
    input  wire logic                     mem_clear_i,
    input  wire logic                     scan_step_i,
    input  wire logic                     convert_i,
    input  wire logic                     conv_done_i,
    input  wire logic         [ADC_W-1:0] adc_data_i,
    output scl_pkg::scl_node_t            pos_node_o,
    output logic                    [5:0] pos_chan_o,
    output scl_pkg::scl_node_t            neg_node_o,
    output logic                    [5:0] neg_chan_o,
    output logic                    [2:0] gain_code_o,
    output logic                    [7:0] gain_sel_o,
    output logic                          unipolar_o,
    output logic                          noise_inject_on_o,
    output logic                    [2:0] input_kind_o,
    output logic                          ghost_o,
    output logic                          acquire_o,
    output logic                          scan_end_mark_o,
    output logic                          scan_pulse_n_o,
    output logic                          fifo_push_o,
    output logic                   [15:0] fifo_data_o,
    output logic                 [AW-1:0] entry_index_o,
    output logic                   [AW:0] entry_count_o,
    output logic                          mem_full_o
);

    // register decode from the board bus
    wire            low_wr  = wr_en_i && (addr_i == SCL_OFS_LOW);
    wire            high_wr = wr_en_i && (addr_i == SCL_OFS_HIGH);

    logic    [31:0] entry;
    logic  [AW-1:0] rd_ptr;
    logic    [AW:0] count;
    logic           full;

    scl_node_t      dec_pos_node;
    logic     [5:0] dec_pos_chan;
    scl_node_t      dec_neg_node;
    logic     [5:0] dec_neg_chan;
    logic     [2:0] dec_gain;
    logic     [7:0] dec_gain_sel;
    logic           dec_unip;
    logic           dec_dither;
    logic           dec_ghost;
    logic           dec_trig;
    logic           dec_end;

    scl_entry_mem #(
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_mem (
        .mclk_i    (mclk_i),
        .rstn_i    (rstn_i),
        .low_wr_i  (low_wr),
        .high_wr_i (high_wr),
        .wdata_i   (wdata_i),
        .clear_i   (mem_clear_i),
        .step_i    (scan_step_i),
        .entry_o   (entry),
        .rd_ptr_o  (rd_ptr),
        .count_o   (count),
        .full_o    (full)
    );

    scl_entry_decode #(
        .FIXED_DITHER (FIXED_DITHER)
    ) u_dec (
        .entry_i     (entry),
        .pos_node_o  (dec_pos_node),
        .pos_chan_o  (dec_pos_chan),
        .neg_node_o  (dec_neg_node),
        .neg_chan_o  (dec_neg_chan),
        .gain_code_o (dec_gain),
        .gain_sel_o  (dec_gain_sel),
        .unipolar_o  (dec_unip),
        .dither_o    (dec_dither),
        .ghost_o     (dec_ghost),
        .trig_o      (dec_trig),
        .end_o       (dec_end)
    );

    // an empty list selects nothing, so stale words never reach the amp
    wire            have_entry = (count != '0);
    wire      [2:0] kind       = entry[16+SCL_KIND_LSB +: SCL_KIND_W];
    // only the four live kinds and ghost are meaningful
    wire            kind_used  = (kind <= SCL_KIND_GROUNDED) || (kind == SCL_KIND_GHOST);
    // ghost and unused kinds acquire nothing
    wire            live       = have_entry && kind_used && !dec_ghost;

    // bank and channel of live entries reach the mux selects
    wire scl_node_t pos_node_d = live ? dec_pos_node : SCL_NODE_OPEN;
    wire scl_node_t neg_node_d = live ? dec_neg_node : SCL_NODE_OPEN;
    wire      [5:0] pos_chan_d = live ? dec_pos_chan : 6'h00;
    wire      [5:0] neg_chan_d = live ? dec_neg_chan : 6'h00;

    // low only while converting a flagged entry
    wire            pulse_n_d  = ~(have_entry & dec_trig & convert_i);

    // ghost conversions are dropped before the FIFO
    wire            push_d     = conv_done_i & live;

    // bipolar results are sign extended to the read width
    wire     [15:0] res_unip   = SCL_RES_W'(adc_data_i);
    wire     [15:0] res_bip    = SCL_RES_W'(signed'(adc_data_i));
    wire     [15:0] result_d   = dec_unip ? res_unip : res_bip;

    scl_node_t      pos_node_q;
    scl_node_t      neg_node_q;
    logic     [5:0] pos_chan_q;
    logic     [5:0] neg_chan_q;
    logic     [2:0] gain_q;
    logic     [7:0] gain_sel_q;
    logic           unip_q;
    logic           dither_q;
    logic     [2:0] kind_q;
    logic           ghost_q;
    logic           acquire_q;
    logic           end_q;
    logic           pulse_n_q;
    logic           push_q;
    logic    [15:0] data_q;
    logic  [AW-1:0] index_q;
    logic    [AW:0] count_q;
    logic           full_q;

    // bank and channel selects held for the amp mux
    // paired negative side comes from the decoder
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pos_node_q <= SCL_NODE_OPEN;
            neg_node_q <= SCL_NODE_OPEN;
            pos_chan_q <= 6'h00;
            neg_chan_q <= 6'h00;
        end else begin
            pos_node_q <= pos_node_d;
            neg_node_q <= neg_node_d;
            pos_chan_q <= pos_chan_d;
            neg_chan_q <= neg_chan_d;
        end
    end

    // gain code and its one-hot select
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gain_q     <= 3'h0;
            gain_sel_q <= 8'h00;
            unip_q     <= 1'b0;
            dither_q   <= FIXED_DITHER;
            kind_q     <= SCL_KIND_CAL;
        end else begin
            // empty list shows reset codes, never unwritten memory
            gain_q     <= have_entry ? dec_gain : 3'h0;
            gain_sel_q <= have_entry ? dec_gain_sel : 8'h00;
            unip_q     <= have_entry & dec_unip;
            dither_q   <= FIXED_DITHER | (have_entry & dec_dither);
            kind_q     <= have_entry ? kind : SCL_KIND_CAL;
        end
    end

    // ghost flag and acquire strobe for the converter
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ghost_q   <= 1'b0;
            acquire_q <= 1'b0;
            end_q     <= 1'b0;
        end else begin
            ghost_q   <= have_entry & dec_ghost;
            acquire_q <= live;
            end_q     <= have_entry & dec_end;
        end
    end

    // trigger pulse towards the timing controller
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pulse_n_q <= SCL_PULSE_IDLE;
        end else begin
            pulse_n_q <= pulse_n_d;
        end
    end

    // result and push strobe for the data FIFO
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            push_q <= 1'b0;
            data_q <= 16'h0000;
        end else begin
            push_q <= push_d;
            if (push_d) begin
                data_q <= result_d;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            index_q <= '0;
            count_q <= '0;
            full_q  <= 1'b0;
        end else begin
            index_q <= rd_ptr;
            count_q <= count;
            full_q  <= full;
        end
    end

    assign pos_node_o        = pos_node_q;
    assign neg_node_o        = neg_node_q;
    assign pos_chan_o        = pos_chan_q;
    assign neg_chan_o        = neg_chan_q;
    assign gain_code_o       = gain_q;
    assign gain_sel_o        = gain_sel_q;
    assign unipolar_o        = unip_q;
    assign noise_inject_on_o = dither_q;
    assign input_kind_o      = kind_q;
    assign ghost_o           = ghost_q;
    assign acquire_o         = acquire_q;
    assign scan_end_mark_o   = end_q;
    assign scan_pulse_n_o    = pulse_n_q;
    assign fifo_push_o       = push_q;
    assign fifo_data_o       = data_q;
    assign entry_index_o     = index_q;
    assign entry_count_o     = count_q;
    assign mem_full_o        = full_q;

endmodule // scl_entry_top

`default_nettype wire

// *** design/scl_pkg.sv ***
`default_nettype none

package scl_pkg;

    // register byte offsets on the board bus
    localparam logic [4:0] SCL_OFS_LOW  = 5'h10;
    localparam logic [4:0] SCL_OFS_HIGH = 5'h12;

    // low half field positions
    localparam int SCL_END_BIT    = 15;
    localparam int SCL_TRIG_BIT   = 12;
    localparam int SCL_DITHER_BIT = 9;
    localparam int SCL_POL_BIT    = 8;
    localparam int SCL_GAIN_LSB   = 0;
    localparam int SCL_GAIN_W     = 3;

    // high half field positions, counted within the high half
    localparam int SCL_KIND_LSB = 12;
    localparam int SCL_KIND_W   = 3;
    localparam int SCL_BANK_LSB = 4;
    localparam int SCL_BANK_W   = 2;
    localparam int SCL_CHAN_LSB = 0;
    localparam int SCL_CHAN_W   = 4;

    // input kind codes
    localparam logic [2:0] SCL_KIND_CAL      = 3'h0;
    localparam logic [2:0] SCL_KIND_PAIRED   = 3'h1;
    localparam logic [2:0] SCL_KIND_FLOATING = 3'h2;
    localparam logic [2:0] SCL_KIND_GROUNDED = 3'h3;
    localparam logic [2:0] SCL_KIND_GHOST    = 3'h7;

    // paired input: negative side is input n plus this offset
    localparam logic [3:0] SCL_PAIR_OFS = 4'h8;

    // reset values
    localparam logic [15:0] SCL_LOW_RST   = 16'h0000;
    localparam logic        SCL_PULSE_IDLE = 1'b1;

    localparam int SCL_RES_W   = 16;
    localparam int SCL_GAIN_N  = 8;

    // amplifier node selected on one side of the input amp
    typedef enum logic [2:0] {
        SCL_NODE_OPEN,
        SCL_NODE_INPUT,
        SCL_NODE_AO_GND,
        SCL_NODE_AI_GND,
        SCL_NODE_DAC0,
        SCL_NODE_DAC1,
        SCL_NODE_REF,
        SCL_NODE_SENSE
    } scl_node_t;

endpackage : scl_pkg

`default_nettype wire

// *** verification/scl_entry_top_properties.sv ***
`default_nettype none

module scl_entry_props
    import scl_pkg::*;
#(
    parameter int AW           = 9,
    parameter int ADC_W        = 12,
    parameter bit FIXED_DITHER = 1'b0
) (
    input wire logic             mclk_i,
    input wire logic             rstn_i,
    input wire logic             wr_en_i,
    input wire logic [4:0]       addr_i,
    input wire logic             mem_clear_i,
    input wire logic             scan_step_i,
    input wire logic             convert_i,
    input wire logic             conv_done_i,
    input wire logic [ADC_W-1:0] adc_data_i,
    input wire logic [2:0]       gain_code_o,
    input wire logic [7:0]       gain_sel_o,
    input wire logic             unipolar_o,
    input wire logic             noise_inject_on_o,
    input wire logic             ghost_o,
    input wire logic             acquire_o,
    input wire logic             scan_pulse_n_o,
    input wire logic             fifo_push_o,
    input wire logic [15:0]      fifo_data_o,
    input wire logic [AW-1:0]    entry_index_o,
    input wire logic [AW:0]      entry_count_o,
    input wire logic             mem_full_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    wire logic [AW:0] nxt_w = {1'b0, entry_index_o} + 1'b1;
    wire logic        hi_wr_w = wr_en_i && addr_i == SCL_OFS_HIGH && !mem_clear_i && !mem_full_o;

    count_advance_a: assert property (hi_wr_w |=> ##1 entry_count_o == $past(entry_count_o) + 1'b1)
        else $error("entry count did not advance after high write");
    clear_empties_a: assert property (mem_clear_i |-> ##2 entry_count_o == '0)
        else $error("clear did not empty the list");
    step_wraps_a: assert property (scan_step_i && !$past(scan_step_i) && entry_count_o != '0
        && !mem_clear_i |-> ##2 {1'b0, entry_index_o} == (($past(nxt_w, 2) == $past(entry_count_o, 2))
        ? '0 : $past(nxt_w, 2)))
        else $error("step did not move to the next entry");
    pulse_in_conv_a: assert property (!scan_pulse_n_o |-> $past(convert_i))
        else $error("trigger pulse outside convert window");
    push_follows_a: assert property (conv_done_i && acquire_o |=> fifo_push_o)
        else $error("live conversion not pushed");
    push_cause_a: assert property (fifo_push_o |-> $past(conv_done_i && acquire_o))
        else $error("push without live conversion");
    ghost_no_push_a: assert property (conv_done_i && ghost_o |=> !fifo_push_o)
        else $error("ghost conversion pushed");
    ghost_no_acq_a: assert property (ghost_o |-> !acquire_o)
        else $error("ghost entry acquires");
    data_format_a: assert property (fifo_push_o |-> fifo_data_o == ($past(unipolar_o)
        ? 16'($past(adc_data_i)) : {{(16 - ADC_W){$past(adc_data_i[ADC_W-1])}}, $past(adc_data_i)}))
        else $error("result format wrong");
    gain_onehot_a: assert property (gain_sel_o != '0 |-> gain_sel_o == (8'h01 << gain_code_o))
        else $error("gain select not one-hot of code");
    dither_fixed_a: assert property (!noise_inject_on_o |-> !FIXED_DITHER)
        else $error("fixed dither turned off");

    cover property (conv_done_i && ghost_o);
    cover property (!scan_pulse_n_o);
    cover property (fifo_push_o && unipolar_o);
    cover property (mem_clear_i);
endmodule // scl_entry_props

bind scl_entry_top scl_entry_props #(.AW(AW), .ADC_W(ADC_W), .FIXED_DITHER(FIXED_DITHER)) props_u (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .wr_en_i(wr_en_i), .addr_i(addr_i),
    .mem_clear_i(mem_clear_i), .scan_step_i(scan_step_i), .convert_i(convert_i),
    .conv_done_i(conv_done_i), .adc_data_i(adc_data_i), .gain_code_o(gain_code_o),
    .gain_sel_o(gain_sel_o), .unipolar_o(unipolar_o), .noise_inject_on_o(noise_inject_on_o),
    .ghost_o(ghost_o), .acquire_o(acquire_o), .scan_pulse_n_o(scan_pulse_n_o),
    .fifo_push_o(fifo_push_o), .fifo_data_o(fifo_data_o), .entry_index_o(entry_index_o),
    .entry_count_o(entry_count_o), .mem_full_o(mem_full_o));

`default_nettype wire

// *** verification/scl_tctl_model.sv ***
`default_nettype none

module scl_tctl_model (
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        conv_req_i,
    input  wire logic        step_req_i,
    input  wire logic        clr_req_i,
    input  wire logic [11:0] adc_val_i,
    output logic             convert_o,
    output logic             conv_done_o,
    output logic             scan_step_o,
    output logic             mem_clear_o,
    output logic      [11:0] adc_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt_q;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= 2'h0;
            convert_o <= 1'b0;
            conv_done_o <= 1'b0;
            scan_step_o <= 1'b0;
            mem_clear_o <= 1'b0;
            adc_data_o <= 12'h000;
        end else begin
            scan_step_o <= step_req_i;
            mem_clear_o <= clr_req_i;
            cnt_q <= conv_req_i ? 2'h3 : cnt_q - 2'(cnt_q != 2'h0);
            convert_o <= conv_req_i || cnt_q > 2'h1;
            conv_done_o <= cnt_q == 2'h2;
            // data line toggles outside done so a stale code never looks valid
            adc_data_o <= (cnt_q == 2'h2) ? adc_val_i : ~adc_data_o;
        end
    end
endmodule // scl_tctl_model

`default_nettype wire

// *** verification/tb_top.sv ***
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import scl_pkg::*;
    logic mclk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, creq = 1'b0, sreq = 1'b0, clreq = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [15:0] wdata = 16'h0000;
    logic [11:0] aval = 12'h000, adc;
    logic mclr, stp, cnv, cdone, uni, dith, ghost, acq, endm, pulse_n, push, full;
    scl_node_t pos_node, neg_node;
    logic [5:0] pos_chan, neg_chan;
    logic [2:0] gain_code, kind;
    logic [7:0] gain_sel;
    logic [15:0] fdata;
    logic [8:0] idx;
    logic [9:0] cnt;
    int n_fail = 0, cmp_count = 0, cyc = 0;
    // reserved bits zero, end mark on entry 4
    logic [15:0] lo_t [9] = '{16'h0200, 16'h1107, 16'h0005, 16'h0106, 16'h8003, 16'h0001,
                              16'h0004, 16'h0004, 16'h0002};
    logic [15:0] hi_t [9] = '{16'h0006, 16'h1013, 16'h202f, 16'h3000, 16'h7005, 16'h5001,
                              16'h1009, 16'h3004, 16'h3038};
    scl_node_t pn_t [9] = '{SCL_NODE_DAC0, SCL_NODE_INPUT, SCL_NODE_INPUT, SCL_NODE_INPUT,
        SCL_NODE_OPEN, SCL_NODE_OPEN, SCL_NODE_OPEN, SCL_NODE_INPUT, SCL_NODE_INPUT};
    scl_node_t nn_t [9] = '{SCL_NODE_REF, SCL_NODE_INPUT, SCL_NODE_SENSE, SCL_NODE_AI_GND,
        SCL_NODE_OPEN, SCL_NODE_OPEN, SCL_NODE_OPEN, SCL_NODE_AI_GND, SCL_NODE_AI_GND};

    always #50 mclk = ~mclk;

    scl_tctl_model tctl_u (.mclk_i(mclk), .rstn_i(rst_n), .conv_req_i(creq), .step_req_i(sreq),
        .clr_req_i(clreq), .adc_val_i(aval), .convert_o(cnv), .conv_done_o(cdone),
        .scan_step_o(stp), .mem_clear_o(mclr), .adc_data_o(adc));

    scl_entry_top dut_u (.mclk_i(mclk), .rstn_i(rst_n), .wr_en_i(wr_en), .addr_i(addr),
        .wdata_i(wdata), .mem_clear_i(mclr), .scan_step_i(stp), .convert_i(cnv),
        .conv_done_i(cdone), .adc_data_i(adc), .pos_node_o(pos_node), .pos_chan_o(pos_chan),
        .neg_node_o(neg_node), .neg_chan_o(neg_chan), .gain_code_o(gain_code),
        .gain_sel_o(gain_sel), .unipolar_o(uni), .noise_inject_on_o(dith), .input_kind_o(kind),
        .ghost_o(ghost), .acquire_o(acq), .scan_end_mark_o(endm), .scan_pulse_n_o(pulse_n),
        .fifo_push_o(push), .fifo_data_o(fdata), .entry_index_o(idx), .entry_count_o(cnt),
        .mem_full_o(full));

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // a run of a few hundred cycles; the ceiling only catches a hang
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
    endtask

    task automatic idle(input int n);
        @(posedge mclk);
        wr_en <= 1'b0;
        sreq <= 1'b0;
        clreq <= 1'b0;
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic t_fill;
        for (int i = 0; i < 9; i++) begin
            if (i != 7) wr(SCL_OFS_LOW, lo_t[i]);
            wr(SCL_OFS_HIGH, hi_t[i]);
        end
        wr(5'h14, 16'h3001);
        idle(3);
        chk("count", 16'h0009, 16'(cnt));
        chk("full", 16'h0000, 16'(full));
        chk("index", 16'h0000, 16'(idx));
    endtask

    task automatic t_walk;
        int k, np;
        logic pl;
        logic [15:0] dt;
        for (int i = 0; i < 10; i++) begin
            k = i % 9;
            chk("index", 16'(k), 16'(idx));
            chk("pos_node", 16'(pn_t[k]), 16'(pos_node));
            chk("neg_node", 16'(nn_t[k]), 16'(neg_node));
            if (pn_t[k] == SCL_NODE_INPUT) chk("pos_chan", hi_t[k][5:0], pos_chan);
            if (nn_t[k] == SCL_NODE_INPUT) chk("neg_chan", hi_t[k][5:0] + 6'h08, neg_chan);
            chk("gain_code", lo_t[k][2:0], gain_code);
            chk("gain_sel", 8'h01 << lo_t[k][2:0], gain_sel);
            chk("unipolar", lo_t[k][8], uni);
            chk("dither", lo_t[k][9], dith);
            chk("kind", hi_t[k][14:12], kind);
            chk("ghost", 16'(hi_t[k][14:12] == 3'h7), 16'(ghost));
            chk("acquire", 16'(hi_t[k][14:12] <= 3'h3), 16'(acq));
            chk("end_mark", lo_t[k][15], endm);
            @(posedge mclk);
            creq <= 1'b1;
            aval <= 12'h800 | 12'(k);
            np = 0;
            pl = 1'b1;
            dt = 16'h0000;
            repeat (7) begin
                @(posedge mclk);
                creq <= 1'b0;
                #1;
                if (pulse_n !== 1'b1) pl = 1'b0;
                if (push === 1'b1) begin
                    np++;
                    dt = fdata;
                end
            end
            chk("push", 16'(hi_t[k][14:12] <= 3'h3), 16'(np));
            if (np != 0) chk("data", {lo_t[k][8] ? 4'h0 : 4'hf, 12'h800 | 12'(k)}, dt);
            chk("pulse_n", 16'(!lo_t[k][12]), 16'(pl));
            @(posedge mclk);
            sreq <= 1'b1;
            idle(5);
        end
    endtask

    task automatic t_clear;
        @(posedge mclk);
        clreq <= 1'b1;
        idle(4);
        chk("count", 16'h0000, 16'(cnt));
        chk("gain_sel", 16'h0000, 16'(gain_sel));
        chk("acquire", 16'h0000, 16'(acq));
        @(posedge mclk);
        sreq <= 1'b1;
        idle(5);
        chk("index", 16'h0000, 16'(idx));
        wr(SCL_OFS_LOW, 16'h0107);
        wr(SCL_OFS_HIGH, 16'h2003);
        idle(4);
        chk("count", 16'h0001, 16'(cnt));
        chk("neg_node", 16'(SCL_NODE_SENSE), 16'(neg_node));
        chk("gain_sel", 16'h0080, 16'(gain_sel));
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        t_fill();
        t_walk();
        t_clear();
        final_report();
    end
endmodule // tb_top

`default_nettype wire
